// file: rtl/bmc_pkg.sv
// Constants and types for the boot and memory-map control block
// Operation
// - Both select pins low: external 48 MHz
// - Both select pins high: 12 MHz crystal
// - Boot map: ROM at 0000 and 8000
// - Boot map: RAM read/write in data space
// - Both maps: I/O window FD80 to FFFF
// - Normal map: ROM only at 8000
// - Normal map: RAM in code space
// - Reset clears map switch and attach
// - First fetch after reset hits ROM
// - Software cannot clear map switch
// - Normal map blocks code-space RAM writes
// - Revision bits 4..1 read-only
// - Bit 6 picks interrupt one source
// - Map switch is bit 0, resets 0
package bmc_pkg;
   // Register index on the plain register port
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] MCU_CFG_OFS = 8'h00;
   localparam logic [REG_AW-1:0] USB_CTL_OFS = 8'h01;
   // Field positions
   localparam int CFG_MAP_BIT = 0;
   localparam int CFG_REV_LSB = 1;
   localparam int CFG_REV_MSB = 4;
   localparam int CFG_IRQ_BIT = 6;
   localparam int USB_ATTACH_BIT = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Revision value is arbitrary
   localparam logic [3:0] REVISION_DEF = 4'h1;
   // Address windows
   localparam logic [15:0] ROM_LO_END = 16'h17FF;
   localparam logic [15:0] ROM_HI_BASE = 16'h8000;
   localparam logic [15:0] ROM_HI_END = 16'h97FF;
   localparam logic [15:0] RAM_END = 16'h1FFF;
   localparam logic [15:0] IO_BASE = 16'hFD80;
   localparam int LOC_AW = 13;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   typedef enum logic [1:0]
   {
      CLK_XTAL = 2'b00,
      CLK_EXT = 2'b01,
      CLK_TEST = 2'b10
   } bmc_clk_src_t;
   typedef enum logic
   {
      MAP_BOOT = 1'b0,
      MAP_NORMAL = 1'b1
   } bmc_map_t;
endpackage

// file: rtl/bmc_top.sv
// Boot map switch, memory decode, config register and clock-source select
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module bmc_top
#(
   parameter logic [3:0] REVISION = bmc_pkg::REVISION_DEF,
   parameter int PORT2_W = 8
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic func_reset_i,
   // Clock-select strap pins
   input wire logic clock_select_pin_a_i,
   input wire logic clock_select_pin_b_i,
   output bmc_pkg::bmc_clk_src_t clk_src_o,
   // Register port
   input wire logic [bmc_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Code space access
   input wire logic [15:0] code_addr_i,
   input wire logic code_rd_i,
   input wire logic code_wr_i,
   output logic code_rom_sel_o,
   output logic code_ram_sel_o,
   output logic code_wr_blocked_o,
   output logic [bmc_pkg::LOC_AW-1:0] code_loc_addr_o,
   // Data space access
   input wire logic [15:0] data_addr_i,
   input wire logic data_rd_i,
   input wire logic data_wr_i,
   output logic data_ram_sel_o,
   output logic data_ram_we_o,
   output logic data_io_sel_o,
   output logic [bmc_pkg::LOC_AW-1:0] data_loc_addr_o,
   // Map and attach state
   output logic boot_map_switch_o,
   output logic usb_attach_bit_o,
   // Interrupt one source
   input wire logic port3_bit3_pin_i,
   input wire logic [PORT2_W-1:0] port2_pins_i,
   output logic external_interrupt_one_o
);
   import bmc_pkg::*;

   logic [1:0] sel_s1;
   logic [1:0] sel_s2;
   logic irq_p3_s1;
   logic irq_p3_s2;
   logic [PORT2_W-1:0] p2_s1;
   logic [PORT2_W-1:0] p2_s2;
   logic boot_map_switch;
   logic irq1_source_select;
   logic usb_attach_bit;
   logic [7:0] next_rdata;
   logic cfg_wr;
   logic usb_wr;

   // Pins are asynchronous: two flops before any logic
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sel_s1 <= 2'h3;
         sel_s2 <= 2'h3;
         irq_p3_s1 <= 1'b0;
         irq_p3_s2 <= 1'b0;
         p2_s1 <= '0;
         p2_s2 <= '0;
      end
      else
      begin
         sel_s1 <= {clock_select_pin_b_i, clock_select_pin_a_i};
         sel_s2 <= sel_s1;
         irq_p3_s1 <= port3_bit3_pin_i;
         irq_p3_s2 <= irq_p3_s1;
         p2_s1 <= port2_pins_i;
         p2_s2 <= p2_s1;
      end
   end

   // Clock source from the strap pair; default is the crystal
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         clk_src_o <= CLK_XTAL;
      else
         case (sel_s2)
            2'h0: clk_src_o <= CLK_EXT;
            2'h3: clk_src_o <= CLK_XTAL;
            // Mixed levels are test-only; flagged, never a mission clock
            default: clk_src_o <= CLK_TEST;
         endcase
   end

   assign cfg_wr = reg_wr_i && (reg_addr_i == MCU_CFG_OFS);
   assign usb_wr = reg_wr_i && (reg_addr_i == USB_CTL_OFS);

   // Map switch: set by software, cleared only by a reset
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         boot_map_switch <= MAP_BOOT;
      else if (func_reset_i)
         boot_map_switch <= MAP_BOOT;
      else if (cfg_wr && reg_wdata_i[CFG_MAP_BIT])
         boot_map_switch <= MAP_NORMAL;
   end

   // Interrupt one source select
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         irq1_source_select <= 1'b0;
      else if (func_reset_i)
         irq1_source_select <= 1'b0;
      else if (cfg_wr)
         irq1_source_select <= reg_wdata_i[CFG_IRQ_BIT];
   end

   // Attach bit stays low until software sets it; the write is taken in either map
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         usb_attach_bit <= 1'b0;
      else if (func_reset_i)
         usb_attach_bit <= 1'b0;
      else if (usb_wr)
         usb_attach_bit <= reg_wdata_i[USB_ATTACH_BIT];
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         boot_map_switch_o <= 1'b0;
         usb_attach_bit_o <= 1'b0;
      end
      else
      begin
         boot_map_switch_o <= boot_map_switch;
         usb_attach_bit_o <= usb_attach_bit;
      end
   end

   // Read mux; revision field ignores writes, reserved bits read zero
   always_comb
   begin
      next_rdata = REG_RESET;
      if (reg_addr_i == MCU_CFG_OFS)
      begin
         next_rdata[CFG_MAP_BIT] = boot_map_switch;
         next_rdata[CFG_REV_MSB:CFG_REV_LSB] = REVISION;
         next_rdata[CFG_IRQ_BIT] = irq1_source_select;
      end
      else if (reg_addr_i == USB_CTL_OFS)
         next_rdata[USB_ATTACH_BIT] = usb_attach_bit;
   end

   // Data only in the cycle after the read strobe
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         reg_rdata_o <= REG_RESET;
      else if (reg_rd_i)
         reg_rdata_o <= next_rdata;
      else
         reg_rdata_o <= REG_RESET;
   end

   // Code space decode, registered one cycle
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         code_rom_sel_o <= 1'b0;
         code_ram_sel_o <= 1'b0;
         code_wr_blocked_o <= 1'b0;
         code_loc_addr_o <= '0;
      end
      else
      begin
         code_rom_sel_o <= 1'b0;
         code_ram_sel_o <= 1'b0;
         code_loc_addr_o <= code_addr_i[LOC_AW-1:0];
         // Code RAM is never write-enabled from here; attempts are flagged in the normal map only
         code_wr_blocked_o <= code_wr_i
            && (boot_map_switch == MAP_NORMAL);
         if (code_rd_i)
         begin
            if (code_addr_i >= ROM_HI_BASE && code_addr_i <= ROM_HI_END)
            begin
               code_rom_sel_o <= 1'b1;
               code_loc_addr_o <= LOC_AW'(code_addr_i - ROM_HI_BASE);
            end
            else if (boot_map_switch == MAP_BOOT)
               // Reset vector lands here, inside the boot ROM
               code_rom_sel_o <= (code_addr_i <= ROM_LO_END);
            else
               code_ram_sel_o <= (code_addr_i <= RAM_END);
         end
      end
   end

   // Data space decode, registered one cycle
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         data_ram_sel_o <= 1'b0;
         data_ram_we_o <= 1'b0;
         data_io_sel_o <= 1'b0;
         data_loc_addr_o <= '0;
      end
      else
      begin
         data_ram_sel_o <= 1'b0;
         data_ram_we_o <= 1'b0;
         data_io_sel_o <= 1'b0;
         data_loc_addr_o <= data_addr_i[LOC_AW-1:0];
         if (data_rd_i || data_wr_i)
         begin
            if (data_addr_i >= IO_BASE)
            begin
               data_io_sel_o <= 1'b1;
               data_loc_addr_o <= LOC_AW'(data_addr_i - IO_BASE);
            end
            else if (boot_map_switch == MAP_BOOT
               && data_addr_i <= RAM_END)
            begin
               data_ram_sel_o <= 1'b1;
               data_ram_we_o <= data_wr_i;
            end
         end
      end
   end

   // Interrupt one routing
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         external_interrupt_one_o <= 1'b0;
      else if (irq1_source_select)
         external_interrupt_one_o <= |p2_s2;
      else
         external_interrupt_one_o <= irq_p3_s2;
   end

   // Checks
   ext_clock_sel_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      sel_s2 == 2'h0 |=> clk_src_o == CLK_EXT)
      else $error("external clock not selected");
   xtal_clock_sel_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      sel_s2 == 2'h3 |=> clk_src_o == CLK_XTAL)
      else $error("crystal not selected");
   test_clock_sel_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_s2 == 2'h1 || sel_s2 == 2'h2) |=> clk_src_o == CLK_TEST)
      else $error("mixed straps not flagged");
   boot_rom_low_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      code_rd_i && !boot_map_switch && code_addr_i <= ROM_LO_END
      |=> code_rom_sel_o && !code_ram_sel_o
      && code_loc_addr_o == $past(code_addr_i[LOC_AW-1:0]))
      else $error("boot ROM low image not decoded");
   boot_data_ram_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      data_wr_i && !boot_map_switch && data_addr_i <= RAM_END
      |=> data_ram_sel_o && data_ram_we_o)
      else $error("boot map data RAM write missing");
   boot_ram_read_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      data_rd_i && !boot_map_switch && data_addr_i <= RAM_END
      |=> data_ram_sel_o && !data_ram_we_o && !data_io_sel_o)
      else $error("boot map data RAM read missing");
   io_window_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (data_rd_i || data_wr_i) && data_addr_i >= IO_BASE
      |=> data_io_sel_o && !data_ram_sel_o
      && data_loc_addr_o == LOC_AW'($past(data_addr_i) - IO_BASE))
      else $error("I/O window not decoded");
   rom_high_normal_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      code_rd_i && boot_map_switch && code_addr_i >= ROM_HI_BASE
      && code_addr_i <= ROM_HI_END |=> code_rom_sel_o && !code_ram_sel_o)
      else $error("normal map high ROM not decoded");
   normal_rom_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      code_rd_i && boot_map_switch && code_addr_i <= RAM_END
      |=> !code_rom_sel_o && code_ram_sel_o)
      else $error("normal map code decode wrong");
   data_ram_moved_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      data_rd_i && boot_map_switch && data_addr_i <= RAM_END
      |=> !data_ram_sel_o)
      else $error("RAM still in data space in normal map");
   normal_data_ram_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      boot_map_switch |=> !data_ram_we_o)
      else $error("RAM write while in normal map");
   code_wr_block_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      code_wr_i && boot_map_switch |=> code_wr_blocked_o)
      else $error("code-space write not blocked");
   sticky_map_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      boot_map_switch && !func_reset_i |=> boot_map_switch)
      else $error("map switch cleared by software");
   func_reset_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      func_reset_i |=> !boot_map_switch && !usb_attach_bit
      ##1 !boot_map_switch_o && !usb_attach_bit_o)
      else $error("function reset did not clear state");
   cfg_read_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      reg_rd_i && reg_addr_i == MCU_CFG_OFS
      |=> reg_rdata_o[CFG_REV_MSB:CFG_REV_LSB] == REVISION
      && reg_rdata_o[5] == 1'b0 && reg_rdata_o[7] == 1'b0
      && reg_rdata_o[CFG_MAP_BIT] == $past(boot_map_switch))
      else $error("config read value wrong");
   cfg_irq_bit_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      reg_rd_i && reg_addr_i == MCU_CFG_OFS
      |=> reg_rdata_o[CFG_IRQ_BIT] == $past(irq1_source_select))
      else $error("interrupt source bit read wrong");
   irq_route_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      irq1_source_select |=> external_interrupt_one_o == $past(|p2_s2))
      else $error("interrupt one not from port 2");
   irq_port3_a: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !irq1_source_select |=> external_interrupt_one_o == $past(irq_p3_s2))
      else $error("interrupt one not from port 3 pin");

   map_switch_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
      !boot_map_switch ##1 boot_map_switch);
   attach_after_map_c: cover property (@(posedge clk_i)
      disable iff (!resetn_i)
      boot_map_switch && usb_wr && reg_wdata_i[USB_ATTACH_BIT]);
   blocked_write_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
      code_wr_blocked_o);
   rom_high_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
      code_rd_i && code_addr_i == ROM_HI_BASE);
   func_reset_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
      func_reset_i && boot_map_switch);
endmodule

// file: verif/bmc_board_model.sv
// Board model that straps the clock-select pins
`timescale 1ns/1ps
module bmc_board_model
(
   // Strap choice from the bench
   input wire logic ext_clk_i,
   // Strap pins
   output logic clock_select_pin_a_o,
   output logic clock_select_pin_b_o
);
   // One net feeds both pins, so a mixed test combo cannot occur
   assign clock_select_pin_a_o = ~ext_clk_i;
   assign clock_select_pin_b_o = ~ext_clk_i;
endmodule

// file: verif/tb.sv
// Self-checking bench for the boot and memory-map control block
`timescale 1ns/1ps
module tb;
   import bmc_pkg::*;
   localparam logic [7:0] CFG0 = {3'h0, REVISION_DEF, 1'b0};
   logic clk, resetn, func_reset, ext_clk, pin_a, pin_b;
   bmc_clk_src_t clk_src;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, port2;
   logic reg_wr, reg_rd, code_rd, code_wr, data_rd, data_wr, port3;
   logic [15:0] code_addr, data_addr;
   logic rom_sel, ram_sel, wr_blk, dram_sel, dram_we, io_sel;
   logic map_sw, attach, irq;
   logic [LOC_AW-1:0] code_loc, data_loc;
   int errors, check_count, cycles;
   bmc_board_model bmc_board_model_inst (.ext_clk_i(ext_clk),
      .clock_select_pin_a_o(pin_a), .clock_select_pin_b_o(pin_b));
   bmc_top bmc_top_inst (.clk_i(clk), .resetn_i(resetn),
      .func_reset_i(func_reset), .clock_select_pin_a_i(pin_a),
      .clock_select_pin_b_i(pin_b), .clk_src_o(clk_src),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .code_addr_i(code_addr),
      .code_rd_i(code_rd), .code_wr_i(code_wr), .code_rom_sel_o(rom_sel),
      .code_ram_sel_o(ram_sel), .code_wr_blocked_o(wr_blk),
      .code_loc_addr_o(code_loc), .data_addr_i(data_addr),
      .data_rd_i(data_rd), .data_wr_i(data_wr), .data_ram_sel_o(dram_sel),
      .data_ram_we_o(dram_we), .data_io_sel_o(io_sel),
      .data_loc_addr_o(data_loc), .boot_map_switch_o(map_sw),
      .usb_attach_bit_o(attach), .port3_bit3_pin_i(port3),
      .port2_pins_i(port2), .external_interrupt_one_o(irq));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input string n, input logic [15:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, exp);
   endtask
   // Code or data access; selects are judged in the cycle after
   task acc(input logic d, input logic [15:0] a, input logic w);
      @(posedge clk);
      code_addr <= a;
      data_addr <= a;
      code_rd <= ~d & ~w;
      code_wr <= ~d & w;
      data_rd <= d & ~w;
      data_wr <= d & w;
      @(posedge clk);
      {code_rd, code_wr, data_rd, data_wr} <= 4'h0;
      #1;
   endtask
   task cchk(input logic [2:0] s, input logic [15:0] loc);
      chk("code_sel", {rom_sel, ram_sel, wr_blk, code_loc}, {s, loc[12:0]});
   endtask
   task dchk(input logic [2:0] s, input logic [15:0] loc);
      chk("data_sel", {dram_sel, dram_we, io_sel, data_loc}, {s, loc[12:0]});
   endtask
   task t_reset;
      chk("map_attach", {map_sw, attach}, 16'h0);
      rd(MCU_CFG_OFS, CFG0);
      rd(USB_CTL_OFS, 8'h00);
      rd(8'h7F, 8'h00);
      chk("clk_src", clk_src, CLK_XTAL);
      $display("test reset done");
   endtask
   task t_boot;
      acc(0, 16'h0000, 0); cchk(3'h4, RESET_VECTOR);
      acc(0, 16'h17FF, 0); cchk(3'h4, 16'h17FF);
      acc(0, 16'h8005, 0); cchk(3'h4, 16'h0005);
      acc(0, 16'h1800, 0); cchk(3'h0, 16'h1800);
      acc(1, 16'h1FFF, 1); dchk(3'h6, 16'h1FFF);
      acc(1, 16'h0000, 0); dchk(3'h4, 16'h0000);
      acc(1, 16'hFFFF, 0); dchk(3'h1, 16'h027F);
      $display("test boot map done");
   endtask
   task t_switch;
      wr(MCU_CFG_OFS, 8'hFF);
      rd(MCU_CFG_OFS, CFG0 | 8'h41);
      wr(MCU_CFG_OFS, 8'h40);
      rd(MCU_CFG_OFS, CFG0 | 8'h41);
      chk("map_sw", map_sw, 16'h1);
      wr(USB_CTL_OFS, 8'h01);
      rd(USB_CTL_OFS, 8'h01);
      chk("attach", attach, 16'h1);
      $display("test map switch done");
   endtask
   task t_normal;
      acc(0, 16'h0010, 0); cchk(3'h2, 16'h0010);
      acc(0, 16'h0000, 0); cchk(3'h2, 16'h0000);
      acc(0, 16'h9000, 0); cchk(3'h4, 16'h1000);
      acc(0, 16'h0004, 1); chk("blk", wr_blk, 16'h1);
      acc(1, 16'hFD80, 1); dchk(3'h1, 16'h0000);
      acc(1, 16'h0000, 1); chk("dram", {dram_sel, dram_we}, 16'h0);
      $display("test normal map done");
   endtask
   task t_irq;
      @(posedge clk);
      port2 <= 8'h04;
      repeat (4) @(posedge clk);
      #1 chk("irq", irq, 16'h1);
      @(posedge clk);
      port2 <= 8'h00;
      port3 <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("irq", irq, 16'h0);
      wr(MCU_CFG_OFS, 8'h00);
      repeat (4) @(posedge clk);
      #1 chk("irq", irq, 16'h1);
      $display("test interrupt source done");
   endtask
   task t_freset;
      @(posedge clk);
      func_reset <= 1'b1;
      @(posedge clk);
      func_reset <= 1'b0;
      repeat (2) @(posedge clk);
      rd(MCU_CFG_OFS, CFG0);
      rd(USB_CTL_OFS, 8'h00);
      acc(0, 16'h0000, 0); cchk(3'h4, RESET_VECTOR);
      $display("test function reset done");
   endtask
   task t_strap;
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("clk_src", clk_src, CLK_EXT);
      @(posedge clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("clk_src", clk_src, CLK_XTAL);
      $display("test clock straps done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Whole run needs under a hundred cycles; the ceiling leaves margin
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         give_verdict();
      end
   end
   initial
   begin
      {resetn, func_reset, ext_clk, reg_wr, reg_rd, port3} = 6'h0;
      {code_rd, code_wr, data_rd, data_wr} = 4'h0;
      {reg_addr, reg_wdata, port2} = 24'h0;
      {code_addr, data_addr} = 32'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_boot();
      t_switch();
      t_normal();
      t_irq();
      t_freset();
      t_strap();
      give_verdict();
   end
endmodule
